/* File: include/cmt_map.svh */
`ifndef CMT_MAP_SVH
`define CMT_MAP_SVH
// register byte offsets
`define CMT_OFS_CTRL   8'h00
`define CMT_OFS_COUNT  8'h04
`define CMT_OFS_PSCLIM 8'h08
`define CMT_OFS_PSCCNT 8'h0C
`define CMT_OFS_MCTL   8'h10
`define CMT_OFS_CCTL   8'h14
`define CMT_OFS_OCTL   8'h18
`define CMT_OFS_STS    8'h1C
`define CMT_OFS_MASK   8'h20
`define CMT_OFS_PINS   8'h24
`define CMT_OFS_INFO   8'h28
`define CMT_OFS_MATCH  8'h30
`define CMT_OFS_CAP    8'h40
// control bits
`define CMT_CTRL_RUN   0
`define CMT_CTRL_CLR   1
`define CMT_CTRL_EXT   2
// per channel field offsets, three bits per channel
`define CMT_MCTL_INT   0
`define CMT_MCTL_RST   1
`define CMT_MCTL_STOP  2
`define CMT_CCTL_RISE  0
`define CMT_CCTL_FALL  1
`define CMT_CCTL_INT   2
// status layout: match flags low, capture flags above
`define CMT_STS_CAP    4
// pin select: and-mode bits above the pin enables
`define CMT_PINS_AND   8
// reset values
`define CMT_RST_WORD   32'h0000_0000
`define CMT_RST_PINS   12'h055
// interrupt controller channel numbers of the two instances
`define CMT_IRQ_CH0    32'h0000_0004
`define CMT_IRQ_CH1    32'h0000_0005
`endif

/* File: include/cmt_pkg.sv */
package cmt_pkg;
	// one data word of the timer
	typedef logic [31:0] cmt_word_t;
	// action of a match output on a match
	typedef enum logic [1:0] {
		CMT_ACT_NONE   = 2'b00,
		CMT_ACT_LOW    = 2'b01,
		CMT_ACT_HIGH   = 2'b10,
		CMT_ACT_TOGGLE = 2'b11
	} cmt_act_t;
endpackage

/* File: include/cmt_evt_if.sv */
`timescale 1ns/1ps
// events passed from the prescaler and capture front end to the core
interface cmt_evt_if;
	logic        tick;    // counter advance pulse
	logic [31:0] psc_cnt; // prescaler count
	logic [3:0]  rise;    // capture rising edge pulses
	logic [3:0]  fall;    // capture falling edge pulses
	modport psc (output tick, output psc_cnt);
	modport edg (output rise, output fall);
	modport core (input tick, input psc_cnt, input rise, input fall);
endinterface

/* File: core/cmt_prescale.sv */
`timescale 1ns/1ps
`include "cmt_map.svh"
module cmt_prescale (
	input  wire logic             sys_clk, // system clock
	input  wire logic             reset_n, // async reset, low
	input  wire logic             run,     // counting enabled
	input  wire logic             clr,     // clear prescaler
	input  wire logic             ext_sel, // count external clock edges
	input  wire logic             ext_clk, // external clock, sampled
	input  wire cmt_pkg::cmt_word_t limit, // prescaler limit
	cmt_evt_if.psc                evt      // tick and count out
);
	import cmt_pkg::*;

	cmt_word_t psc_r, psc_nxt;   // prescaler count
	logic      tick_r, tick_nxt; // advance pulse
	logic      ext_r, ext_nxt;   // previous external sample
	logic      src;              // one source cycle

	// source is every clock or each rising external edge
	always_comb begin
		src = ext_sel ? (ext_clk & ~ext_r) : 1'b1;
		ext_nxt = ext_clk;
		psc_nxt = psc_r;
		tick_nxt = 1'b0;
		if (clr) begin
			psc_nxt = `CMT_RST_WORD;
		end else if (run && src) begin
			// wrap at the limit and advance the counter
			if (psc_r >= limit) begin
				psc_nxt = `CMT_RST_WORD;
				tick_nxt = 1'b1;
			end else begin
				psc_nxt = psc_r + 32'h0000_0001;
			end
		end
	end

	// register the prescaler state
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			psc_r <= `CMT_RST_WORD;
			tick_r <= 1'b0;
			ext_r <= 1'b0;
		end else begin
			psc_r <= psc_nxt;
			tick_r <= tick_nxt;
			ext_r <= ext_nxt;
		end
	end

	assign evt.tick = tick_r;
	assign evt.psc_cnt = psc_r;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	chk_ext_tick_edge: assert property (ext_sel && run && !clr && psc_r >= limit
		&& ext_clk && !ext_r |=> tick_r) else $error("external edge at limit gave no tick");
	chk_ext_no_edge: assert property (ext_sel && !clr && !(ext_clk && !ext_r)
		|=> !tick_r && $stable(psc_r)) else $error("prescaler moved without edge");
endmodule

/* File: core/cmt_capin.sv */
`timescale 1ns/1ps
`include "cmt_map.svh"
module cmt_capin (
	input  wire logic       sys_clk,  // system clock
	input  wire logic       reset_n,  // async reset, low
	input  wire logic [7:0] cap_pin,  // two capture pins per channel
	input  wire logic [7:0] pin_en,   // pin enables
	input  wire logic [3:0] and_mode, // combine by and instead of or
	cmt_evt_if.edg          evt       // edge pulses out
);
	import cmt_pkg::*;

	logic [3:0] lvl_r, lvl_nxt; // combined level per channel

	// combine the enabled pins of one channel
	function automatic logic combine(input logic [1:0] p, input logic [1:0] e,
		input logic a);
		combine = a ? ((|e) && &(p | ~e)) : |(p & e);
	endfunction

	// next combined levels
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			lvl_nxt[i] = combine(cap_pin[2*i +: 2], pin_en[2*i +: 2], and_mode[i]);
		end
	end

	// register the levels
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			lvl_r <= 4'h0;
		end else begin
			lvl_r <= lvl_nxt;
		end
	end

	// transitions of the combined level
	assign evt.rise = lvl_nxt & ~lvl_r;
	assign evt.fall = ~lvl_nxt & lvl_r;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	chk_cap_and_mode: assert property (and_mode[0] && pin_en[1:0] == 2'b11
		|=> lvl_r[0] == ($past(cap_pin[1:0]) == 2'b11)) else $error("and combine wrong");
	chk_cap_or_mode: assert property (!and_mode[1] && pin_en[3:2] == 2'b11
		|=> lvl_r[1] == ($past(cap_pin[3:2]) != 2'b00)) else $error("or combine wrong");
endmodule

/* File: core/cmt_top.sv */
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "cmt_map.svh"
module cmt_top #(
	parameter bit INSTANCE = 1'b0 // zero or one instance
) (
	input  wire logic              sys_clk,   // 100 MHz clock
	input  wire logic              reset_n,   // async reset, low
	input  wire logic [7:0]        addr,      // register byte address
	input  wire cmt_pkg::cmt_word_t wdata,    // write data
	input  wire logic              wr_en,     // write strobe
	input  wire logic              rd_en,     // read strobe
	output      cmt_pkg::cmt_word_t rdata,    // read data, next cycle
	input  wire logic [7:0]        cap_pin,   // capture pins
	input  wire logic              ext_clk,   // external count clock
	output      logic [3:0]        match_out, // match outputs
	output      logic [7:0]        match_pin, // broadcast match pins
	output      logic              irq        // interrupt request
);
	import cmt_pkg::*;

	cmt_evt_if evt ();                  // internal event bundle

	logic [2:0]  ctrl_r, ctrl_nxt;      // run, clear, external
	cmt_word_t   psc_lim_r, psc_lim_nxt; // prescaler limit
	logic [11:0] mctl_r, mctl_nxt;      // match actions
	logic [11:0] cctl_r, cctl_nxt;      // capture edges and int
	logic [7:0]  octl_r, octl_nxt;      // output actions
	logic [11:0] pins_r, pins_nxt;      // pin enables, and-mode
	logic [7:0]  mask_r, mask_nxt;      // interrupt mask
	logic [7:0]  sts_r, sts_nxt;        // sticky status
	cmt_word_t   cnt_r, cnt_nxt;        // timer count
	cmt_word_t   match_r [4];           // match values
	cmt_word_t   match_nxt [4];
	cmt_word_t   cap_r [4];             // captured values
	cmt_word_t   cap_nxt [4];
	logic [3:0]  mout_r, mout_nxt;      // match output levels
	logic [7:0]  mpin_r, mpin_nxt;      // broadcast pins
	cmt_word_t   rdata_r, rdata_nxt;    // read data
	logic        irq_r, irq_nxt;        // interrupt level

	logic        run;                   // counting enabled
	logic        tick_ok;               // counter advances now
	logic [3:0]  hit;                   // match events
	logic [3:0]  cap_evt;               // capture events
	logic        rst_hit;               // some match resets
	logic        stop_hit;              // some match stops
	logic        psc_clr;               // prescaler clear
	logic        rd_sts;                // status read

	// byte offset of channel i of a register array
	function automatic logic [7:0] reg_ofs(input logic [7:0] base, input int i);
		reg_ofs = base + 8'(i * 4);
	endfunction

	// one field bit of channel i in a three-bit-per-channel register
	function automatic logic chan_bit(input logic [11:0] v, input int i, input int f);
		chan_bit = v[3*i + f];
	endfunction

	// prescaler and external clock source
	cmt_prescale u_psc (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.run     (run),
		.clr     (psc_clr),
		.ext_sel (ctrl_r[`CMT_CTRL_EXT]),
		.ext_clk (ext_clk),
		.limit   (psc_lim_r),
		.evt     (evt.psc)
	);

	// capture pin combining and edge detection
	cmt_capin u_cap (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.cap_pin  (cap_pin),
		.pin_en   (pins_r[7:0]),
		.and_mode (pins_r[`CMT_PINS_AND +: 4]),
		.evt      (evt.edg)
	);

	// event decode
	always_comb begin
		run = ctrl_r[`CMT_CTRL_RUN] & ~ctrl_r[`CMT_CTRL_CLR];
		tick_ok = run & evt.tick;
		rst_hit = 1'b0;
		stop_hit = 1'b0;
		for (int i = 0; i < 4; i++) begin
			hit[i] = tick_ok && (cnt_r == match_r[i]);
			rst_hit = rst_hit | (hit[i] & chan_bit(mctl_r, i, `CMT_MCTL_RST));
			stop_hit = stop_hit | (hit[i] & chan_bit(mctl_r, i, `CMT_MCTL_STOP));
			cap_evt[i] = (evt.rise[i] & chan_bit(cctl_r, i, `CMT_CCTL_RISE))
				| (evt.fall[i] & chan_bit(cctl_r, i, `CMT_CCTL_FALL));
		end
		psc_clr = ctrl_r[`CMT_CTRL_CLR] | rst_hit;
		rd_sts = rd_en && (addr == `CMT_OFS_STS);
	end

	// next values of registers, counter, captures and outputs
	always_comb begin
		ctrl_nxt = ctrl_r;
		psc_lim_nxt = psc_lim_r;
		mctl_nxt = mctl_r;
		cctl_nxt = cctl_r;
		octl_nxt = octl_r;
		pins_nxt = pins_r;
		mask_nxt = mask_r;
		match_nxt = match_r;
		cap_nxt = cap_r;
		mout_nxt = mout_r;
		// software writes
		if (wr_en) begin
			unique case (addr)
				`CMT_OFS_CTRL:   ctrl_nxt = wdata[2:0];
				`CMT_OFS_PSCLIM: psc_lim_nxt = wdata;
				`CMT_OFS_MCTL:   mctl_nxt = wdata[11:0];
				`CMT_OFS_CCTL:   cctl_nxt = wdata[11:0];
				`CMT_OFS_OCTL:   octl_nxt = wdata[7:0];
				`CMT_OFS_PINS:   pins_nxt = wdata[11:0];
				`CMT_OFS_MASK:   mask_nxt = wdata[7:0];
				default: begin
					// match values or ignored address
					for (int i = 0; i < 4; i++) begin
						if (addr == reg_ofs(`CMT_OFS_MATCH, i)) begin
							match_nxt[i] = wdata;
						end
					end
				end
			endcase
		end
		// stop on match overrides a write of the run bit
		if (stop_hit) begin
			ctrl_nxt[`CMT_CTRL_RUN] = 1'b0;
		end
		// counter: hold-clear, reset on match, advance with wrap
		if (ctrl_r[`CMT_CTRL_CLR]) begin
			cnt_nxt = `CMT_RST_WORD;
		end else if (rst_hit) begin
			cnt_nxt = `CMT_RST_WORD;
		end else if (tick_ok) begin
			cnt_nxt = cnt_r + 32'h0000_0001;
		end else begin
			cnt_nxt = cnt_r;
		end
		// captures and match outputs
		for (int i = 0; i < 4; i++) begin
			if (cap_evt[i]) begin
				cap_nxt[i] = cnt_r;
			end
			if (hit[i]) begin
				unique case (cmt_act_t'(octl_r[2*i +: 2]))
					CMT_ACT_NONE:   mout_nxt[i] = mout_r[i];
					CMT_ACT_LOW:    mout_nxt[i] = 1'b0;
					CMT_ACT_HIGH:   mout_nxt[i] = 1'b1;
					CMT_ACT_TOGGLE: mout_nxt[i] = ~mout_r[i];
				endcase
			end
		end
		// each match output drives two pins
		mpin_nxt = {mout_nxt, mout_nxt};
		// status: read clears, new events win
		sts_nxt = rd_sts ? 8'h00 : sts_r;
		for (int i = 0; i < 4; i++) begin
			if (hit[i] && chan_bit(mctl_r, i, `CMT_MCTL_INT)) begin
				sts_nxt[i] = 1'b1;
			end
			if (cap_evt[i] && chan_bit(cctl_r, i, `CMT_CCTL_INT)) begin
				sts_nxt[`CMT_STS_CAP + i] = 1'b1;
			end
		end
	end

	// register the timer state
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r <= 3'h0;
			psc_lim_r <= `CMT_RST_WORD;
			mctl_r <= 12'h000;
			cctl_r <= 12'h000;
			octl_r <= 8'h00;
			pins_r <= `CMT_RST_PINS;
			mask_r <= 8'h00;
			sts_r <= 8'h00;
			cnt_r <= `CMT_RST_WORD;
			match_r <= '{default: `CMT_RST_WORD};
			cap_r <= '{default: `CMT_RST_WORD};
			mout_r <= 4'h0;
			mpin_r <= 8'h00;
		end else begin
			ctrl_r <= ctrl_nxt;
			psc_lim_r <= psc_lim_nxt;
			mctl_r <= mctl_nxt;
			cctl_r <= cctl_nxt;
			octl_r <= octl_nxt;
			pins_r <= pins_nxt;
			mask_r <= mask_nxt;
			sts_r <= sts_nxt;
			cnt_r <= cnt_nxt;
			match_r <= match_nxt;
			cap_r <= cap_nxt;
			mout_r <= mout_nxt;
			mpin_r <= mpin_nxt;
		end
	end

	// read mux and merged interrupt level
	always_comb begin
		rdata_nxt = `CMT_RST_WORD;
		if (rd_en) begin
			unique case (addr)
				`CMT_OFS_CTRL:   rdata_nxt = {29'h0, ctrl_r};
				`CMT_OFS_COUNT:  rdata_nxt = cnt_r;
				`CMT_OFS_PSCLIM: rdata_nxt = psc_lim_r;
				`CMT_OFS_PSCCNT: rdata_nxt = evt.psc_cnt;
				`CMT_OFS_MCTL:   rdata_nxt = {20'h0, mctl_r};
				`CMT_OFS_CCTL:   rdata_nxt = {20'h0, cctl_r};
				`CMT_OFS_OCTL:   rdata_nxt = {24'h0, octl_r};
				`CMT_OFS_STS:    rdata_nxt = {24'h0, sts_r};
				`CMT_OFS_MASK:   rdata_nxt = {24'h0, mask_r};
				`CMT_OFS_PINS:   rdata_nxt = {20'h0, pins_r};
				`CMT_OFS_INFO:   rdata_nxt = INSTANCE ? `CMT_IRQ_CH1 : `CMT_IRQ_CH0;
				default: begin
					// match and capture arrays, else zero
					for (int i = 0; i < 4; i++) begin
						if (addr == reg_ofs(`CMT_OFS_MATCH, i)) begin
							rdata_nxt = match_r[i];
						end
						if (addr == reg_ofs(`CMT_OFS_CAP, i)) begin
							rdata_nxt = cap_r[i];
						end
					end
				end
			endcase
		end
		irq_nxt = |(sts_nxt & mask_nxt);
	end

	// register read data and interrupt
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_r <= `CMT_RST_WORD;
			irq_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign rdata = rdata_r;
	assign match_out = mout_r;
	assign match_pin = mpin_r;
	assign irq = irq_r;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	sequence s_reset_hit;
		rst_hit && !ctrl_r[`CMT_CTRL_CLR];
	endsequence
	sequence s_stop_hit;
		stop_hit && !(wr_en && addr == `CMT_OFS_CTRL);
	endsequence
	sequence s_plain_tick;
		tick_ok && !rst_hit && !ctrl_r[`CMT_CTRL_CLR];
	endsequence

	chk_cnt_only_tick: assert property (!tick_ok && !ctrl_r[`CMT_CTRL_CLR]
		|=> $stable(cnt_r)) else $error("count moved without tick");
	chk_cnt_step_wrap: assert property (s_plain_tick
		|=> cnt_r == $past(cnt_r) + 32'h0000_0001) else $error("bad count step");
	chk_cap_copy: assert property (cap_evt[0]
		|=> cap_r[0] == $past(cnt_r)) else $error("capture lost count");
	chk_cap_int_gate: assert property ($rose(sts_r[`CMT_STS_CAP])
		|-> $past(cap_evt[0]) && $past(cctl_r[`CMT_CCTL_INT])) else $error("capture flag");
	chk_match_runs_on: assert property (hit[0] && mctl_r[2:0] == 3'b001 && !rst_hit
		&& !stop_hit |=> sts_r[0] && cnt_r == $past(cnt_r) + 32'h0000_0001)
		else $error("continuous match wrong");
	chk_match_stop: assert property (s_stop_hit
		|=> !ctrl_r[`CMT_CTRL_RUN] ##1 !tick_ok) else $error("stop on match failed");
	chk_match_reset: assert property (s_reset_hit
		|=> cnt_r == `CMT_RST_WORD) else $error("reset on match failed");
	chk_out_toggle: assert property (hit[0] && octl_r[1:0] == 2'b11
		|=> match_out[0] != $past(match_out[0])) else $error("toggle failed");
	chk_out_hold: assert property (!hit[1]
		|=> $stable(match_out[1])) else $error("output moved without match");
	chk_pin_bcast: assert property (1'b1
		|-> match_pin == {match_out, match_out}) else $error("broadcast mismatch");
	chk_irq_line: assert property (irq == |(sts_r & mask_r))
		else $error("interrupt line mismatch");
endmodule

/* File: testbench/cmt_pins_model.sv */
`timescale 1ns/1ps
// far side of the timer pins: capture sources, external clock, match pin watch
module cmt_pins_model (
	input  wire logic        sys_clk,   // system clock
	input  wire logic        reset_n,   // async reset, low
	input  wire logic [7:0]  cap_lvl,   // wanted capture levels
	input  wire logic        ext_run,   // let the external clock run
	input  wire logic [7:0]  match_pin, // broadcast match pins
	output      logic [7:0]  cap_pin,   // capture pins
	output      logic        ext_clk,   // external count clock
	output      logic [31:0] ext_edges, // rising edges produced
	output      logic        bcast_ok   // both pins of each output agree
);
	logic [1:0] div_r; // divider phase of the external clock
	// levels are changed by the bench just after an edge
	assign cap_pin = cap_lvl;
	// each match output must reach both of its pins
	assign bcast_ok = (match_pin[3:0] === match_pin[7:4]);
	// a full period always completes, so the clock stands low when stopped
	assign ext_clk = div_r[1];
	// divider and edge counter
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			div_r     <= 2'h0;
			ext_edges <= 32'h0000_0000;
		end else if (ext_run || (div_r != 2'h0)) begin
			div_r <= div_r + 2'h1;
			// rising edge of the slow clock
			if (div_r == 2'h1) begin
				ext_edges <= ext_edges + 32'h0000_0001;
			end
		end
	end
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`include "cmt_map.svh"
module testbench;
	import cmt_pkg::*;
	logic        sys_clk;   // 100 MHz clock
	logic        reset_n;   // async reset, low
	logic [7:0]  addr;      // register address
	cmt_word_t   wdata;     // write data
	cmt_word_t   rdata;     // read data, first instance
	cmt_word_t   rdata_b;   // read data, second instance
	logic        wr_en;     // write strobe
	logic        rd_en;     // read strobe
	logic [7:0]  cap_lvl;   // wanted capture levels
	logic [7:0]  cap_pin;   // capture pins
	logic        ext_run;   // external clock enable
	logic        ext_clk;   // external clock
	logic [31:0] ext_edges; // edges made by the model
	logic        bcast_ok;  // broadcast pins agree
	logic [3:0]  match_out; // match outputs
	logic [7:0]  match_pin; // broadcast match pins
	logic        irq;       // interrupt request
	cmt_word_t   v;         // last value read
	cmt_word_t   c;         // saved value
	int          err_count; // mismatches
	int          compares;  // comparisons made
	int          cycles;    // cycles since start
	cmt_top #(.INSTANCE(1'b0)) i_cmt_top (.sys_clk(sys_clk), .reset_n(reset_n), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .cap_pin(cap_pin),
		.ext_clk(ext_clk), .match_out(match_out), .match_pin(match_pin), .irq(irq));
	// second instance shares the bus, only its read data is watched
	cmt_top #(.INSTANCE(1'b1)) i_cmt_top_b (.sys_clk(sys_clk), .reset_n(reset_n), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata_b), .cap_pin(cap_pin),
		.ext_clk(ext_clk), .match_out(), .match_pin(), .irq());
	cmt_pins_model i_cmt_pins_model (.sys_clk(sys_clk), .reset_n(reset_n), .cap_lvl(cap_lvl),
		.ext_run(ext_run), .match_pin(match_pin), .cap_pin(cap_pin), .ext_clk(ext_clk),
		.ext_edges(ext_edges), .bcast_ok(bcast_ok));
	// clock
	always #5 sys_clk = ~sys_clk;
	// compare and count
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one write cycle
	task automatic wr(input logic [7:0] a, input cmt_word_t d);
		@(posedge sys_clk);
		wr_en <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask
	// one read cycle, data taken in the following cycle
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		rd_en <= 1'b1;
		addr  <= a;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1 v = rdata;
	endtask
	// read and compare
	task automatic rdc(input string what, input logic [7:0] a, input cmt_word_t e);
		rd(a);
		chk(what, v, e);
	endtask
	// idle cycles
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// clear count and prescaler, then run with a limit
	task automatic restart(input cmt_word_t lim);
		wr(`CMT_OFS_CTRL, 32'h0000_0002);
		wr(`CMT_OFS_PSCLIM, lim);
		wr(`CMT_OFS_CTRL, 32'h0000_0001);
	endtask
	// verdict
	task automatic summarize();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			summarize();
		end
	end
	// main sequence
	initial begin
		sys_clk = 1'b0;
		reset_n = 1'b0;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		wr_en = 1'b0;
		rd_en = 1'b0;
		cap_lvl = 8'h00;
		ext_run = 1'b0;
		wt(5);
		reset_n <= 1'b1;
		// reset values, read-only and unmapped places
		rdc("ctrl", `CMT_OFS_CTRL, 32'h0000_0000);
		rdc("pins", `CMT_OFS_PINS, 32'h0000_0055);
		rd(`CMT_OFS_INFO);
		chk("info0", v, `CMT_IRQ_CH0);
		chk("info1", rdata_b, `CMT_IRQ_CH1);
		rdc("unmapped", 8'h2C, 32'h0000_0000);
		wr(`CMT_OFS_COUNT, 32'h1234_5678);
		rdc("count ro", `CMT_OFS_COUNT, 32'h0000_0000);
		// two captures forty cycles apart, limit 3: ten counts apart
		wr(`CMT_OFS_CCTL, 32'h0000_000D);
		wr(`CMT_OFS_MASK, 32'h0000_0030);
		restart(32'h0000_0003);
		wt(10);
		cap_lvl <= 8'h01;
		wt(40);
		cap_lvl <= 8'h05;
		wt(3);
		chk("cap irq", irq, 1'b1);
		rd(`CMT_OFS_CAP);
		c = v;
		rd(`CMT_OFS_CAP + 8'h04);
		chk("cap span", v - c, 32'h0000_000A);
		rd(`CMT_OFS_STS);
		chk("cap flags", v[7:4], 4'h1);
		rd(`CMT_OFS_PSCCNT);
		chk("psc range", v <= 32'h0000_0003, 1'b1);
		wt(2);
		chk("irq cleared", irq, 1'b0);
		// and-combined capture on two pins
		wr(`CMT_OFS_CCTL, 32'h0000_0001);
		wr(`CMT_OFS_PINS, 32'h0000_0103);
		cap_lvl <= 8'h00;
		rd(`CMT_OFS_CAP);
		c = v;
		cap_lvl <= 8'h01;
		wt(5);
		rdc("and one pin", `CMT_OFS_CAP, c);
		cap_lvl <= 8'h03;
		wt(5);
		rd(`CMT_OFS_CAP);
		chk("and both pins", v > c, 1'b1);
		// or-combined capture on the second pin of channel one, then its falling edge
		wr(`CMT_OFS_CCTL, 32'h0000_0008);
		wr(`CMT_OFS_PINS, 32'h0000_000C);
		rd(`CMT_OFS_CAP + 8'h04);
		c = v;
		cap_lvl <= 8'h0B;
		wt(5);
		rd(`CMT_OFS_CAP + 8'h04);
		chk("or one pin", v > c, 1'b1);
		c = v;
		wr(`CMT_OFS_CCTL, 32'h0000_0010);
		cap_lvl <= 8'h03;
		wt(5);
		rd(`CMT_OFS_CAP + 8'h04);
		chk("fall edge", v > c, 1'b1);
		// stop on match, with its interrupt flag
		wr(`CMT_OFS_MCTL, 32'h0000_0005);
		wr(`CMT_OFS_MATCH, 32'h0000_0005);
		restart(32'h0000_0001);
		wt(30);
		rdc("stop run", `CMT_OFS_CTRL, 32'h0000_0000);
		rd(`CMT_OFS_COUNT);
		c = v;
		chk("stop value", (c >= 32'h0000_0005) && (c <= 32'h0000_0006), 1'b1);
		wt(10);
		rdc("stop held", `CMT_OFS_COUNT, c);
		rd(`CMT_OFS_STS);
		chk("stop flag", v[0], 1'b1);
		// reset on match 1 with interrupt, continuous interrupt on match 0
		wr(`CMT_OFS_MCTL, 32'h0000_0019);
		wr(`CMT_OFS_MATCH, 32'h0000_0002);
		wr(`CMT_OFS_MATCH + 8'h04, 32'h0000_0003);
		rdc("match1", `CMT_OFS_MATCH + 8'h04, 32'h0000_0003);
		restart(32'h0000_0000);
		for (int i = 0; i < 6; i++) begin
			rd(`CMT_OFS_COUNT);
			chk("reset bound", v <= 32'h0000_0003, 1'b1);
		end
		rd(`CMT_OFS_STS);
		chk("match flags", v[1:0], 2'h3);
		// output actions: all toggle, then high, low, toggle, none
		wr(`CMT_OFS_MCTL, 32'h0000_0000);
		for (int i = 0; i < 4; i++) begin
			wr(`CMT_OFS_MATCH + 8'(4 * i), 32'h0000_0002);
		end
		wr(`CMT_OFS_OCTL, 32'h0000_00FF);
		restart(32'h0000_0000);
		wt(20);
		chk("toggle all", match_out, 4'hF);
		wr(`CMT_OFS_OCTL, 32'h0000_0036);
		restart(32'h0000_0000);
		wt(20);
		chk("mixed actions", match_out, 4'h9);
		chk("broadcast", match_pin, 32'h0000_0099);
		chk("broadcast pair", bcast_ok, 1'b1);
		// external clock event counting
		wr(`CMT_OFS_CTRL, 32'h0000_0002);
		wr(`CMT_OFS_CTRL, 32'h0000_0005);
		ext_run <= 1'b1;
		wt(60);
		ext_run <= 1'b0;
		wt(10);
		rdc("ext count", `CMT_OFS_COUNT, ext_edges);
		summarize();
	end
endmodule
